/* rtl/iopm_port_mode.sv */
/*
 * port mode select: four configurable ports, registers on apb.
 * assumes a synchronous environment, logic-array terms and configuration
 * straps driven as stable levels by the surrounding chip.
 */
// Behaviour
// - stored-config modes are inputs; others register-driven
// - control bit zero selects mcu io
// - output data drives, input reads pin
// - ports c, d have no control register
// - driver enable is direction or oe term
// - logic output tri-stated when both inactive
// - address out needs oe or dir and ctrl
// - non-multiplexed bus gives a7-a0 on port b; here only ctrl_b selects them on port b, non_mux_bus plays no part
// - high address inputs latched by address strobe
// - data port mode disables port a io
// - map bit 7 enables peripheral buffer
// - peripheral buffer off without select terms
// - scan pins enabled by three means
// - registers read and written over bus
// - bit n controls pin n
// - registers reset to zero
// - direction one output, zero input
// - port d direction holds three bits
`include "iopm_params.svh"
`timescale 1ns/1ps
`default_nettype none

module iopm_port_mode
    import iopm_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire iopm_array_t array_a,
    input wire iopm_array_t array_b,
    input wire iopm_array_t array_c,
    input wire iopm_array_t array_d,
    input wire logic data_port_mode,
    input wire logic non_mux_bus,
    input wire logic peripheral_select_0,
    input wire logic peripheral_select_1,
    input wire logic [7:0] host_data_out,
    output logic [7:0] host_data_in,
    input wire logic [15:0] host_address,
    input wire logic address_latch_strobe,
    output logic [7:0] latched_high_address,
    input wire logic scan_select_term,
    input wire logic scan_config,
    input wire logic scan_enable_setting,
    output logic scan_pins_enabled,
    input wire logic [7:0] pin_a_in,
    input wire logic [7:0] pin_b_in,
    input wire logic [7:0] pin_c_in,
    input wire logic [2:0] pin_d_in,
    output iopm_pins_t pin_a,
    output iopm_pins_t pin_b,
    output iopm_pins_t pin_c,
    output iopm_pins_t pin_d
);

    // configuration and data registers, one byte each
    logic [7:0] ctrl_a, ctrl_b, dir_a, dir_b, dir_c, dir_d;
    logic [7:0] out_a, out_b, out_c, out_d, map_ctrl;
    logic [7:0] next_ctrl_a, next_ctrl_b, next_dir_a, next_dir_b, next_dir_c, next_dir_d;
    logic [7:0] next_out_a, next_out_b, next_out_c, next_out_d, next_map_ctrl;
    // next values of the bus answer
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic wr_done, rd_hit;
    // driver enables and the low address byte offered to ports a and b
    logic [7:0] en_a, en_b, en_c, en_d, lat_addr;
    logic [7:0] in_d_word;
    // next values of the registered pin and host-side outputs
    iopm_pins_t next_a, next_b, next_c, next_d;
    logic [7:0] next_host_in, next_high_addr;
    logic next_scan;

    // zero-wait slave: every access completes in its first access cycle
    // write strobe: only the access cycle of a write stores
    assign wr_done = psel & penable & pwrite;
    // port d has three pins, its upper input bits read as zero
    assign in_d_word = {5'b0_0000, pin_d_in};

    // enables count oe term or direction
    // driver enable is direction or oe term
    assign en_a = dir_a | array_a.oe_term;
    assign en_b = dir_b | array_b.oe_term;
    assign en_c = dir_c | array_c.oe_term;
    assign en_d = (dir_d | array_d.oe_term) & `IOPM_PORT_D_MASK;
    // low address byte for non-multiplexed hosts
    // taken live, not latched, so it follows the host bus each cycle
    assign lat_addr = host_address[7:0];

    // register writes
    always_comb begin
        next_ctrl_a = ctrl_a;
        next_ctrl_b = ctrl_b;
        next_dir_a = dir_a;
        next_dir_b = dir_b;
        next_dir_c = dir_c;
        next_dir_d = dir_d;
        next_out_a = out_a;
        next_out_b = out_b;
        next_out_c = out_c;
        next_out_d = out_d;
        next_map_ctrl = map_ctrl;
        // read-only and unmapped offsets hit the default: such writes are dropped
        // host write cycle
        if (wr_done) begin
            case (paddr)
                `IOPM_OFF_CTRL_A: next_ctrl_a = pwdata[7:0];
                `IOPM_OFF_CTRL_B: next_ctrl_b = pwdata[7:0];
                `IOPM_OFF_DIR_A: next_dir_a = pwdata[7:0];
                `IOPM_OFF_DIR_B: next_dir_b = pwdata[7:0];
                `IOPM_OFF_DIR_C: next_dir_c = pwdata[7:0];
                `IOPM_OFF_DIR_D: next_dir_d = pwdata[7:0] & `IOPM_PORT_D_MASK;
                `IOPM_OFF_OUT_A: next_out_a = pwdata[7:0];
                `IOPM_OFF_OUT_B: next_out_b = pwdata[7:0];
                `IOPM_OFF_OUT_C: next_out_c = pwdata[7:0];
                `IOPM_OFF_OUT_D: next_out_d = pwdata[7:0] & `IOPM_PORT_D_MASK;
                `IOPM_OFF_MAP: next_map_ctrl = pwdata[7:0];
                default: next_map_ctrl = map_ctrl;
            endcase
        end
    end

    // all registers clear at reset
    // the reset branch loads constants only, nothing from the bus
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_a <= `IOPM_RESET_BYTE;
            ctrl_b <= `IOPM_RESET_BYTE;
            dir_a <= `IOPM_RESET_BYTE;
            dir_b <= `IOPM_RESET_BYTE;
            dir_c <= `IOPM_RESET_BYTE;
            dir_d <= `IOPM_RESET_BYTE;
            out_a <= `IOPM_RESET_BYTE;
            out_b <= `IOPM_RESET_BYTE;
            out_c <= `IOPM_RESET_BYTE;
            out_d <= `IOPM_RESET_BYTE;
            map_ctrl <= `IOPM_RESET_BYTE;
        end else begin
            ctrl_a <= next_ctrl_a;
            ctrl_b <= next_ctrl_b;
            dir_a <= next_dir_a;
            dir_b <= next_dir_b;
            dir_c <= next_dir_c;
            dir_d <= next_dir_d;
            out_a <= next_out_a;
            out_b <= next_out_b;
            out_c <= next_out_c;
            out_d <= next_out_d;
            map_ctrl <= next_map_ctrl;
        end
    end

    // readback, registered in setup so it stands in the access cycle
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        rd_hit = 1'b1;
        if (psel & ~penable) begin
            case (paddr)
                `IOPM_OFF_CTRL_A: next_prdata[7:0] = ctrl_a;
                `IOPM_OFF_CTRL_B: next_prdata[7:0] = ctrl_b;
                `IOPM_OFF_DIR_A: next_prdata[7:0] = dir_a;
                `IOPM_OFF_DIR_B: next_prdata[7:0] = dir_b;
                `IOPM_OFF_DIR_C: next_prdata[7:0] = dir_c;
                `IOPM_OFF_DIR_D: next_prdata[7:0] = dir_d;
                `IOPM_OFF_OUT_A: next_prdata[7:0] = out_a;
                `IOPM_OFF_OUT_B: next_prdata[7:0] = out_b;
                `IOPM_OFF_OUT_C: next_prdata[7:0] = out_c;
                `IOPM_OFF_OUT_D: next_prdata[7:0] = out_d;
                `IOPM_OFF_MAP: next_prdata[7:0] = map_ctrl;
                `IOPM_OFF_IN_A: next_prdata[7:0] = pin_a_in;
                `IOPM_OFF_IN_B: next_prdata[7:0] = pin_b_in;
                `IOPM_OFF_IN_C: next_prdata[7:0] = pin_c_in;
                `IOPM_OFF_IN_D: next_prdata[7:0] = in_d_word;
                `IOPM_OFF_EN_A: next_prdata[7:0] = en_a;
                `IOPM_OFF_EN_B: next_prdata[7:0] = en_b;
                `IOPM_OFF_EN_C: next_prdata[7:0] = en_c;
                `IOPM_OFF_EN_D: next_prdata[7:0] = en_d;
                default: rd_hit = 1'b0;
            endcase
            next_pslverr = ~rd_hit;
        end else if (psel & penable) begin
            // hold through the access cycle; the master takes data with ready
            next_prdata = prdata;
            next_pslverr = pslverr;
        end
    end

    // pin multiplexers, per-bit so bit n drives pin n
    always_comb begin
        next_a = '0;
        next_b = '0;
        next_c = '0;
        next_d = '0;
        // address out wins over a logic cell, which wins over the data register
        for (int i = 0; i < 8; i++) begin
            // control zero selects mcu data; one selects address
            next_a.out[i] = ctrl_a[i] ? lat_addr[i] : out_a[i];
            next_b.out[i] = ctrl_b[i] ? lat_addr[i] : out_b[i];
            // ports c and d lack control, logic cell when defined
            next_c.out[i] = array_c.cell_defined[i] ? array_c.cell_out[i] : out_c[i];
            if (array_a.cell_defined[i] & ~ctrl_a[i]) begin
                next_a.out[i] = array_a.cell_out[i];
            end
            if (array_b.cell_defined[i] & ~ctrl_b[i]) begin
                next_b.out[i] = array_b.cell_out[i];
            end
            if (i < 3) begin
                next_d.out[i] = array_d.cell_defined[i] ? array_d.cell_out[i] : out_d[i];
            end
        end
        // output pins driven from output data
        // tri-state when oe term and direction both low
        next_a.oe = en_a;
        next_b.oe = en_b;
        next_c.oe = en_c;
        next_d.oe = en_d;
        // peripheral mode turns port a into a data buffer
        if (map_ctrl[`IOPM_PERIPH_BIT]) begin
            // buffer off unless a select term active
            next_a.oe = (peripheral_select_0 | peripheral_select_1) ? 8'hFF : 8'h00;
            next_a.out = host_data_out;
        end
        // data port mode disables general io
        // fixed modes come from configuration inputs
        // the strap outranks peripheral mode: port a then belongs to the host bus
        if (data_port_mode) begin
            next_a.oe = 8'h00;
            next_a.out = 8'h00;
        end
        // non-multiplexed bus: port a output forced low only in data port mode
        if (non_mux_bus) begin
            next_a.out = data_port_mode ? 8'h00 : next_a.out;
        end
    end

    // host-side views: data from port a, high address latch
    always_comb begin
        // both hold their last value unless captured below
        next_host_in = host_data_in;
        next_high_addr = latched_high_address;
        // only read through the buffer while selected
        if (map_ctrl[`IOPM_PERIPH_BIT] & (peripheral_select_0 | peripheral_select_1)) begin
            next_host_in = pin_a_in;
        end
        if (address_latch_strobe) begin
            next_high_addr = host_address[15:8];
        end
        // any of three enables scan pins
        next_scan = scan_select_term | scan_config | scan_enable_setting;
    end

    // output flops
    // pins lag their cause by one cycle, the cost of registered outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_a <= '0;
            pin_b <= '0;
            pin_c <= '0;
            pin_d <= '0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
            host_data_in <= 8'h00;
            latched_high_address <= 8'h00;
            scan_pins_enabled <= 1'b0;
        end else begin
            pin_a <= next_a;
            pin_b <= next_b;
            pin_c <= next_c;
            pin_d <= next_d;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            // zero wait states: ready follows the setup cycle
            pready <= psel & ~penable;
            host_data_in <= next_host_in;
            latched_high_address <= next_high_addr;
            scan_pins_enabled <= next_scan;
        end
    end

endmodule // iopm_port_mode

`default_nettype wire

/* rtl/iopm_params.svh */
/*
 * offsets, field positions and reset values of the port mode select block.
 * assumes inclusion by the top module only.
 */
`ifndef IOPM_PARAMS_SVH
`define IOPM_PARAMS_SVH

// register byte offsets on the apb slave
`define IOPM_OFF_CTRL_A 12'h000
`define IOPM_OFF_CTRL_B 12'h004
`define IOPM_OFF_DIR_A 12'h008
`define IOPM_OFF_DIR_B 12'h00C
`define IOPM_OFF_DIR_C 12'h010
`define IOPM_OFF_DIR_D 12'h014
`define IOPM_OFF_OUT_A 12'h018
`define IOPM_OFF_OUT_B 12'h01C
`define IOPM_OFF_OUT_C 12'h020
`define IOPM_OFF_OUT_D 12'h024
`define IOPM_OFF_MAP 12'h028
`define IOPM_OFF_IN_A 12'h02C
`define IOPM_OFF_IN_B 12'h030
`define IOPM_OFF_IN_C 12'h034
`define IOPM_OFF_IN_D 12'h038
`define IOPM_OFF_EN_A 12'h03C
`define IOPM_OFF_EN_B 12'h040
`define IOPM_OFF_EN_C 12'h044
`define IOPM_OFF_EN_D 12'h048

// field positions and reset values
`define IOPM_PERIPH_BIT 7
`define IOPM_RESET_BYTE 8'h00
`define IOPM_PORT_D_MASK 8'h07

`endif

/* rtl/iopm_pkg.sv */
/*
 * types of the port mode select block.
 * assumes the params header sits beside it.
 */
package iopm_pkg;
    // logic array terms for one 8-bit port
    typedef struct packed {
        logic [7:0] oe_term;
        logic [7:0] cell_out;
        logic [7:0] cell_defined;
    } iopm_array_t;
    // a pin group as two signals
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } iopm_pins_t;
endpackage

/* bench/iopm_port_mode_sva.sv */
/* checker for the port mode select block.
   assumes a bind onto iopm_port_mode and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module iopm_port_mode_chk
    import iopm_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire iopm_array_t array_c,
    input wire logic address_latch_strobe,
    input wire logic [15:0] host_address,
    input wire logic [7:0] latched_high_address,
    input wire logic scan_select_term,
    input wire logic scan_config,
    input wire logic scan_enable_setting,
    input wire logic scan_pins_enabled,
    input wire iopm_pins_t pin_c,
    input wire iopm_pins_t pin_d
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // bus answers and error figures
    apb_answer_a: assert property (psel && !penable |=> pready) else $error("late ready");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    bad_addr_a: assert property (psel && !penable && !pwrite && paddr > 12'h048 |=> pslverr)
        else $error("no error on unmapped read");
    // registered outputs follow their causes
    scan_or_a: assert property (!$past(rst) |-> scan_pins_enabled ==
        $past(scan_select_term | scan_config | scan_enable_setting)) else $error("scan enable wrong");
    latch_take_a: assert property (address_latch_strobe |=>
        latched_high_address == $past(host_address[15:8])) else $error("address not latched");
    latch_hold_a: assert property (!address_latch_strobe |=> $stable(latched_high_address))
        else $error("latch moved");
    port_d_a: assert property (pin_d.out[7:3] == 5'h00 && pin_d.oe[7:3] == 5'h00)
        else $error("port d upper bits");
    oe_or_a: assert property (!$past(rst) |->
        (pin_c.oe & $past(array_c.oe_term)) == $past(array_c.oe_term)) else $error("oe term ignored");
endmodule // iopm_port_mode_chk
bind iopm_port_mode iopm_port_mode_chk chk_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .array_c(array_c),
    .address_latch_strobe(address_latch_strobe), .host_address(host_address),
    .latched_high_address(latched_high_address), .scan_select_term(scan_select_term),
    .scan_config(scan_config), .scan_enable_setting(scan_enable_setting),
    .scan_pins_enabled(scan_pins_enabled), .pin_c(pin_c), .pin_d(pin_d));
`default_nettype wire

/* bench/iopm_pin_world.sv */
/* pin world beside the ports: resolves each pin level.
   assumes an outside driver level ext on undriven pins. */
`timescale 1ns/1ps
`default_nettype none
module iopm_pin_world
    import iopm_pkg::*;
(
    input wire iopm_pins_t pin_a,
    input wire iopm_pins_t pin_b,
    input wire iopm_pins_t pin_c,
    input wire iopm_pins_t pin_d,
    input wire logic [7:0] ext,
    output logic [7:0] pin_a_in,
    output logic [7:0] pin_b_in,
    output logic [7:0] pin_c_in,
    output logic [2:0] pin_d_in
);
    // driven bits show the block, the rest the outside driver
    assign pin_a_in = (pin_a.oe & pin_a.out) | (~pin_a.oe & ext);
    assign pin_b_in = (pin_b.oe & pin_b.out) | (~pin_b.oe & ext);
    assign pin_c_in = (pin_c.oe & pin_c.out) | (~pin_c.oe & ext);
    assign pin_d_in = (pin_d.oe[2:0] & pin_d.out[2:0]) | (~pin_d.oe[2:0] & ext[2:0]);
endmodule // iopm_pin_world
`default_nettype wire

/* bench/tb_io_port_mode_select.sv */
/* self-checking bench for the port mode select block.
   assumes the pin world model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_io_port_mode_select;
    import iopm_pkg::*;
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e, son;
    logic dpm = 0, nmb = 0, ps0 = 0, ps1 = 0, als = 0, sst = 0, scf = 0, sen = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic [7:0] hdo = 8'h00, hdi, lha, ext = 8'h00, pai, pbi, pci;
    logic [2:0] pdi;
    logic [15:0] haddr = 16'h0000;
    iopm_array_t aa = '0, ab = '0, ac = '0, ad = '0;
    iopm_pins_t pa, pb, pc, pd;
    int fail_count = 0, n_compared = 0;
    always #4 clock = ~clock;
    iopm_port_mode dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .array_a(aa),
        .array_b(ab), .array_c(ac), .array_d(ad), .data_port_mode(dpm), .non_mux_bus(nmb),
        .peripheral_select_0(ps0), .peripheral_select_1(ps1), .host_data_out(hdo), .host_data_in(hdi),
        .host_address(haddr), .address_latch_strobe(als), .latched_high_address(lha),
        .scan_select_term(sst), .scan_config(scf), .scan_enable_setting(sen), .scan_pins_enabled(son),
        .pin_a_in(pai), .pin_b_in(pbi), .pin_c_in(pci), .pin_d_in(pdi), .pin_a(pa), .pin_b(pb),
        .pin_c(pc), .pin_d(pd));
    iopm_pin_world far (.pin_a(pa), .pin_b(pb), .pin_c(pc), .pin_d(pd), .ext(ext), .pin_a_in(pai),
        .pin_b_in(pbi), .pin_c_in(pci), .pin_d_in(pdi));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one transfer, request held until ready is sampled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees ready
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk("prdata", r, exp);
        chk("pslverr", e, 1'b0);
    endtask
    // pins are registered one cycle behind the cause
    task automatic settle;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic t_rw;
        for (int a = 0; a <= 'h48; a += 4) rdc(a[11:0], 32'h0000_0000);
        for (int a = 0; a <= 'h24; a += 4) apb(1'b1, a[11:0], 32'hFFFF_FF5A);
        for (int a = 0; a <= 'h24; a += 4) rdc(a[11:0], (a % 'h10 == 4 && a > 4) ? 2 : 'h5A);
        for (int a = 0; a <= 'h24; a += 4) apb(1'b1, a[11:0], 32'h0000_0000);
        apb(1'b0, 12'h04C, 32'h0000_0000);
        chk("pslverr", e, 1'b1);
    endtask
    task automatic t_mcu_io;
        @(posedge clock);
        ext <= 8'h3C;
        apb(1'b1, 12'h008, 32'h0000_000F);
        apb(1'b1, 12'h018, 32'h0000_00A5);
        apb(1'b1, 12'h014, 32'h0000_00FF);
        apb(1'b1, 12'h024, 32'h0000_00FD);
        settle;
        chk("pa_oe", pa.oe, 8'h0F);
        chk("pa_out", pa.out & 8'h0F, 8'h05);
        chk("pd_oe", pd.oe, 8'h07);
        chk("pd_out", pd.out, 8'h05);
        rdc(12'h02C, 32'h0000_0035);
        rdc(12'h03C, 32'h0000_000F);
        rdc(12'h038, 32'h0000_0005);
        rdc(12'h048, 32'h0000_0007);
    endtask
    task automatic t_addr_out;
        @(posedge clock);
        nmb <= 1'b1;
        haddr <= 16'h12C3;
        // host sets control and direction before using address out
        apb(1'b1, 12'h004, 32'h0000_00FF);
        apb(1'b1, 12'h00C, 32'h0000_00F0);
        settle;
        chk("pb_oe", pb.oe, 8'hF0);
        chk("pb_out", pb.out & 8'hF0, 8'hC0);
    endtask
    // direction left clear on logic pins
    task automatic t_logic;
        @(posedge clock);
        ac <= {8'h81, 8'h01, 8'h81};
        settle;
        chk("pc_out", pc.out & 8'h81, 8'h01);
        @(posedge clock);
        ac.oe_term <= 8'h00;
        settle;
        chk("pc_oe", pc.oe, 8'h00);
    endtask
    task automatic t_periph;
        @(posedge clock);
        hdo <= 8'h96;
        apb(1'b1, 12'h028, 32'h0000_0080);
        settle;
        chk("pa_oe", pa.oe, 8'h00);
        @(posedge clock);
        ps1 <= 1'b1;
        settle;
        chk("pa_out", {pa.oe, pa.out, hdi}, 24'hFF_9696);
        @(posedge clock);
        ps1 <= 1'b0;
        apb(1'b1, 12'h028, 32'h0000_0000);
        @(posedge clock);
        dpm <= 1'b1;
        settle;
        chk("pa_oe", pa.oe, 8'h00);
    endtask
    task automatic t_strobe;
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            {sst, scf, sen} <= 3'b001 << i;
            settle;
            chk("scan", son, 1'b1);
        end
        @(posedge clock);
        {sst, scf, sen} <= 3'b000;
        als <= 1'b1;
        settle;
        chk("scan", son, 1'b0);
        chk("latch", lha, 8'h12);
    endtask
    // mid-run reset clears registers written earlier
    task automatic t_reset;
        @(posedge clock);
        als <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        chk("latch", lha, 8'h00);
        rdc(12'h004, 32'h0000_0000);
        rdc(12'h008, 32'h0000_0000);
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        t_rw;
        t_mcu_io;
        t_addr_out;
        t_logic;
        t_periph;
        t_strobe;
        t_reset;
        results;
    end
    // watchdog against a hung handshake
    initial begin
        #100000;
        fail_count++;
        results;
    end
endmodule // tb_io_port_mode_select
`default_nettype wire
